// File: inc/step_ctrl_pkg.sv
// Constants, state codes and strobe carriers for the front-panel step control
package step_ctrl_pkg;
  // Clock and machine-cycle timing
  localparam int CLK_NS = 10;
  localparam int SLOT_NS = 200;
  localparam int SLOT_CYC = SLOT_NS / CLK_NS;
  localparam int SLOTS_PER_CYCLE = 8;
  localparam int STROBE_MIN_NS = 45;
  localparam int STROBE_MAX_NS = 55;
  localparam int STROBE_CYC = (STROBE_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int STROBE_MAX_CYC = STROBE_MAX_NS / CLK_NS;
  localparam int INCR_NS = 400;
  localparam int INCR_CYC = INCR_NS / CLK_NS;

  // Slot and sub-slot positions
  localparam logic [2:0] SLOT_ZERO = 3'h0;
  localparam logic [2:0] SLOT_ONE = 3'h1;
  localparam logic [2:0] SLOT_TWO = 3'h2;
  localparam logic [2:0] SLOT_SIX = 3'h6;
  localparam logic [2:0] SLOT_SEVEN = 3'h7;
  localparam logic [4:0] SUB_FIRST = 5'h00;
  localparam logic [4:0] SUB_LAST = 5'(SLOT_CYC - 1);
  localparam logic [4:0] SUB_STROBE = 5'(STROBE_CYC);

  // Register port map and reset values
  localparam logic [1:0] REG_CTRL = 2'h0;
  localparam logic [1:0] REG_STATUS = 2'h1;
  localparam logic [7:0] CTRL_RESET = 8'h01;
  localparam int CTRL_PANEL_EN_BIT = 0;

  // Run control state, one-hot
  typedef enum logic [2:0] {
    ST_HALT = 3'b001,
    ST_STEP = 3'b010,
    ST_DISP = 3'b100
  } run_state_t;

  // Decoder strobes towards the arithmetic cards
  typedef struct packed {
    logic t_clear;
    logic t_read;
    logic [2:0] incr;
    logic [6:0] store;
  } decode_strobe_t;

  // Phase-logic controls
  typedef struct packed {
    logic run_enable;
    logic phase_reset;
    logic phase_three;
    logic phase_one_to_three_gate;
    logic memory_timing_enable;
  } phase_ctrl_t;
endpackage

// File: logic/step_ctrl.sv
// Front-panel single-step and display-memory step control
`timescale 1ns/1ps
module step_ctrl (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Operator switches
  input wire logic single_step_switch,
  input wire logic display_memory_switch,
  // Register port
  input wire logic [1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  // Panel indicators and phase logic
  output logic run_cycle_flag,
  output logic run_cycle_flag_n,
  output logic single_step_request,
  output logic display_memory_request,
  output logic start_pulse,
  output step_ctrl_pkg::phase_ctrl_t phase,
  // Instruction decoder strobes
  output step_ctrl_pkg::decode_strobe_t strobe
);
  logic [4:0] sub;
  logic [2:0] slot;
  logic [4:0] next_sub;
  logic [2:0] next_slot;
  logic step_sync_first;
  logic step_sync_second;
  logic dm_mode;
  logic [7:0] ctrl;
  step_ctrl_pkg::run_state_t state;
  step_ctrl_pkg::run_state_t next_state;
  logic next_first;
  logic next_second;
  logic next_ss_req;
  logic next_dm_req;
  logic next_dm_mode;
  logic next_pulse;
  logic [7:0] next_ctrl;
  logic [7:0] next_rdata;
  step_ctrl_pkg::phase_ctrl_t next_phase;
  step_ctrl_pkg::decode_strobe_t next_strobe;
  logic t1_now;
  logic t2_now;
  logic t7s_now;
  logic pressed;
  logic accept;
  logic panel_en;

  // True at the first cycle of the given slot
  function automatic logic slot_start(input logic [2:0] s,
                                      input logic [4:0] u,
                                      input logic [2:0] want);
    slot_start = (s == want) && (u == step_ctrl_pkg::SUB_FIRST);
  endfunction

  // True in the first strobe-width cycles of the given slot
  function automatic logic slot_head(input logic [2:0] s,
                                     input logic [4:0] u,
                                     input logic [2:0] want);
    slot_head = (s == want) && (u < step_ctrl_pkg::SUB_STROBE);
  endfunction

  // Machine-cycle slot generator
  always_comb begin
    next_sub = sub + 5'h01;
    next_slot = slot;
    if (sub == step_ctrl_pkg::SUB_LAST) begin
      next_sub = step_ctrl_pkg::SUB_FIRST;
      next_slot = slot + 3'h1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sub <= 5'h00;
      slot <= 3'h0;
    end else begin
      sub <= next_sub;
      slot <= next_slot;
    end
  end

  // Slot strobes seen by the step logic
  assign t1_now = slot_start(slot, sub, step_ctrl_pkg::SLOT_ONE);
  assign t2_now = slot_start(slot, sub, step_ctrl_pkg::SLOT_TWO);
  assign t7s_now = (slot == step_ctrl_pkg::SLOT_SEVEN) &&
                   (sub == step_ctrl_pkg::SUB_LAST);
  assign panel_en = ctrl[step_ctrl_pkg::CTRL_PANEL_EN_BIT];
  assign pressed = single_step_switch | display_memory_switch;
  // Gate opens only while halted; a held switch keeps its latch
  assign accept = ~run_cycle_flag & panel_en;

  // Request latch, step synchronisers and start pulse
  always_comb begin
    next_ss_req = single_step_switch &
                  (single_step_request | (accept & ~display_memory_request));
    next_dm_req = display_memory_switch &
                  (display_memory_request | (accept & ~single_step_request));
    if (!single_step_switch) begin
      next_ss_req = 1'b0;
    end
    next_dm_mode = dm_mode;
    if (accept && !single_step_request && !display_memory_request) begin
      next_dm_mode = display_memory_switch;
    end
    next_first = step_sync_first;
    if (t2_now) begin
      next_first = single_step_request | display_memory_request;
    end
    next_second = step_sync_second;
    if (t1_now) begin
      next_second = step_sync_first;
    end
    // Edge of the pair is the pulse, so a held switch gives only one
    next_pulse = next_first & ~next_second;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      single_step_request <= 1'b0;
      display_memory_request <= 1'b0;
      dm_mode <= 1'b0;
      step_sync_first <= 1'b0;
      step_sync_second <= 1'b0;
      start_pulse <= 1'b0;
    end else begin
      single_step_request <= next_ss_req;
      display_memory_request <= next_dm_req;
      dm_mode <= next_dm_mode;
      step_sync_first <= next_first;
      step_sync_second <= next_second;
      start_pulse <= next_pulse;
    end
  end

  // Run flag: decided only at late slot seven, so it spans one machine cycle
  always_comb begin
    next_state = state;
    if (t7s_now) begin
      if (start_pulse && dm_mode) begin
        next_state = step_ctrl_pkg::ST_DISP;
      end else if (start_pulse) begin
        next_state = step_ctrl_pkg::ST_STEP;
      end else begin
        next_state = step_ctrl_pkg::ST_HALT;
      end
    end
  end

  // Phase controls and decoder strobes, aligned to the next slot count
  always_comb begin
    next_phase = '0;
    next_strobe = '0;
    unique case (next_state)
      step_ctrl_pkg::ST_HALT: begin
        next_phase = '0;
      end
      step_ctrl_pkg::ST_STEP: begin
        next_phase.run_enable = 1'b1;
      end
      step_ctrl_pkg::ST_DISP: begin
        next_phase.run_enable = 1'b1;
        next_phase.phase_three = 1'b1;
        next_phase.phase_one_to_three_gate = 1'b1;
        next_phase.memory_timing_enable = 1'b1;
        next_strobe.t_clear = slot_head(next_slot, next_sub,
                                        step_ctrl_pkg::SLOT_ZERO);
        next_strobe.t_read = slot_head(next_slot, next_sub,
                                       step_ctrl_pkg::SLOT_TWO);
        // Slots six and seven together give the 400 ns transfer
        next_strobe.incr = {3{next_slot >= step_ctrl_pkg::SLOT_SIX}};
        next_strobe.store = {7{slot_head(next_slot, next_sub,
                                 step_ctrl_pkg::SLOT_SEVEN)}};
      end
    endcase
    // Phase reset pulse marks the display entry at late slot seven
    next_phase.phase_reset = t7s_now & start_pulse & dm_mode;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= step_ctrl_pkg::ST_HALT;
      run_cycle_flag <= 1'b0;
      run_cycle_flag_n <= 1'b1;
      phase <= '0;
      strobe <= '0;
    end else begin
      state <= next_state;
      run_cycle_flag <= (next_state != step_ctrl_pkg::ST_HALT);
      run_cycle_flag_n <= (next_state == step_ctrl_pkg::ST_HALT);
      phase <= next_phase;
      strobe <= next_strobe;
    end
  end

  // Register port: control enables the panel, status shows step state
  always_comb begin
    next_ctrl = ctrl;
    next_rdata = 8'h00;
    if (wr && addr == step_ctrl_pkg::REG_CTRL) begin
      next_ctrl = wdata;
    end
    if (rd) begin
      unique case (addr)
        step_ctrl_pkg::REG_CTRL: next_rdata = ctrl;
        step_ctrl_pkg::REG_STATUS: next_rdata = {slot, dm_mode,
          start_pulse, run_cycle_flag, step_sync_second, step_sync_first};
        default: next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl <= step_ctrl_pkg::CTRL_RESET;
      rdata <= 8'h00;
    end else begin
      ctrl <= next_ctrl;
      rdata <= next_rdata;
    end
  end

  // Helper counters of pulse and run lengths for the checks below
  logic [7:0] pulse_len;
  logic [7:0] run_len;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pulse_len <= 8'h00;
      run_len <= 8'h00;
    end else begin
      pulse_len <= start_pulse ? pulse_len + 8'h01 : 8'h00;
      run_len <= run_cycle_flag ? run_len + 8'h01 : 8'h00;
    end
  end

  sequence s_short_strobe(sig);
    sig [*5] ##1 !sig;
  endsequence

  sequence s_incr_strobe;
    strobe.incr[0] [*8] ##32 strobe.incr[0] ##1 !strobe.incr[0];
  endsequence

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_busy_ignores_press: assert property (
    run_cycle_flag && !single_step_request && !display_memory_request
    |=> !single_step_request && !display_memory_request)
    else $error("request accepted while running");
  a_release_drops_req: assert property (
    !single_step_switch |=> !single_step_request)
    else $error("request held after release");
  a_first_at_slot_two: assert property (
    $changed(step_sync_first) |-> $past(t2_now))
    else $error("first synchroniser moved off slot two");
  a_second_at_slot_one: assert property (
    $changed(step_sync_second) |-> $past(t1_now))
    else $error("second synchroniser moved off slot one");
  // Counters hold the full length in the cycle where the level falls
  a_pulse_width: assert property (
    $fell(start_pulse) |-> pulse_len ==
    8'(step_ctrl_pkg::SLOT_CYC * (step_ctrl_pkg::SLOTS_PER_CYCLE - 1)))
    else $error("start pulse not 1.4 us");
  a_run_one_cycle: assert property (
    $fell(run_cycle_flag) |-> run_len ==
    8'(step_ctrl_pkg::SLOT_CYC * step_ctrl_pkg::SLOTS_PER_CYCLE))
    else $error("run flag not one machine cycle");
  a_run_inverse: assert property (
    run_cycle_flag_n == !run_cycle_flag)
    else $error("inverted run flag mismatch");
  a_disp_phase_three: assert property (
    $rose(run_cycle_flag) && dm_mode |-> phase.phase_three &&
    phase.phase_one_to_three_gate && phase.phase_reset)
    else $error("display cycle without phase three");
  a_clear_width: assert property (
    $rose(strobe.t_clear) |-> s_short_strobe(strobe.t_clear))
    else $error("clear strobe width wrong");
  a_incr_width: assert property (
    $rose(strobe.incr[0]) |-> s_incr_strobe)
    else $error("increment strobe not 400 ns");
  a_store_width: assert property (
    $rose(strobe.store[0]) |-> s_short_strobe(strobe.store[6]))
    else $error("store strobe width wrong");
  a_read_in_slot_two: assert property (
    strobe.t_read |-> phase.memory_timing_enable &&
    slot == step_ctrl_pkg::SLOT_TWO)
    else $error("read outside slot two");
endmodule

// File: verif/panel_model.sv
// Operator panel model: momentary switches held for a set number of cycles
`timescale 1ns/1ps
module panel_model (
  // Clock
  input wire logic clk,
  // Press commands from the bench
  input wire logic press_step,
  input wire logic press_disp,
  input wire logic [15:0] hold,
  // Switch contacts towards the panel logic
  output logic single_step_switch,
  output logic display_memory_switch
);
  logic [15:0] left_step;
  logic [15:0] left_disp;
  initial begin
    left_step = 16'h0000;
    left_disp = 16'h0000;
  end
  // A press holds the contact closed; release is clean, no bounce modelled
  always @(posedge clk) begin
    if (press_step) left_step <= hold;
    else if (left_step != 16'h0000) left_step <= left_step - 16'h0001;
    if (press_disp) left_disp <= hold;
    else if (left_disp != 16'h0000) left_disp <= left_disp - 16'h0001;
  end
  assign single_step_switch = (left_step != 16'h0000);
  assign display_memory_switch = (left_disp != 16'h0000);
endmodule

// File: verif/test_step_ctrl.sv
// Self-checking bench for the front-panel step control
`timescale 1ns/1ps
module test_step_ctrl;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [1:0] addr = 2'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic press_step = 1'b0;
  logic press_disp = 1'b0;
  logic [15:0] hold = 16'h012c;
  logic sw_step, sw_disp, run_d;
  logic [7:0] rdata, v;
  logic run_cycle_flag, run_cycle_flag_n, start_pulse;
  logic single_step_request, display_memory_request;
  step_ctrl_pkg::phase_ctrl_t phase;
  step_ctrl_pkg::decode_strobe_t strobe;
  int c[0:11];
  int ci[0:2];
  int cs[0:6];
  int fail_count = 0;
  int n_tests = 0;

  always #5 clk = ~clk;

  panel_model u_panel_model (.clk(clk), .press_step(press_step),
    .press_disp(press_disp), .hold(hold), .single_step_switch(sw_step),
    .display_memory_switch(sw_disp));

  step_ctrl u_step_ctrl (.clk(clk), .rst(rst), .single_step_switch(sw_step),
    .display_memory_switch(sw_disp), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .run_cycle_flag(run_cycle_flag),
    .run_cycle_flag_n(run_cycle_flag_n),
    .single_step_request(single_step_request),
    .display_memory_request(display_memory_request),
    .start_pulse(start_pulse), .phase(phase), .strobe(strobe));

  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got %0h expected %0h", $time, seen, exp);
    end
  endtask

  task finish_test;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task reg_write(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task reg_read(input logic [1:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  // Per-cycle activity counts; the inverse flag must mirror the run flag
  always @(posedge clk) begin
    run_d <= run_cycle_flag;
    if (!rst) begin
      check(run_cycle_flag_n, !run_cycle_flag);
      c[0] += start_pulse;
      c[1] += run_cycle_flag;
      c[2] += phase.run_enable;
      c[3] += phase.phase_three;
      c[4] += phase.phase_one_to_three_gate;
      c[5] += phase.memory_timing_enable;
      c[6] += strobe.t_clear;
      c[7] += strobe.t_read;
      c[8] += (run_cycle_flag & ~run_d);
      c[9] += single_step_request;
      c[10] += display_memory_request;
      c[11] += phase.phase_reset;
      for (int i = 0; i < 3; i++) ci[i] += strobe.incr[i];
      for (int i = 0; i < 7; i++) cs[i] += strobe.store[i];
    end
  end

  // One press, then a window long enough for sync, run and release;
  // with inj a short display press lands inside the running cycle
  task press(input bit disp, input bit live, input bit inj);
    int e[0:11];
    int d;
    d = (live && disp) ? 160 : 0;
    e = '{live ? 140 : 0, live ? 160 : 0, live ? 160 : 0, d, d, d,
          d / 32, d / 32, live ? 1 : 0, live && !disp ? 300 : 0,
          live && disp ? 300 : 0, d / 160};
    for (int i = 0; i < 12; i++) c[i] = 0;
    for (int i = 0; i < 3; i++) ci[i] = 0;
    for (int i = 0; i < 7; i++) cs[i] = 0;
    @(posedge clk);
    hold <= 16'h012c;
    if (disp) press_disp <= 1'b1;
    else press_step <= 1'b1;
    @(posedge clk);
    press_disp <= 1'b0;
    press_step <= 1'b0;
    // Injected press is released before the run ends; both the closed
    // gate and the still-held single-step request refuse it
    repeat (700) begin
      @(posedge clk);
      if (inj && run_cycle_flag && !run_d) begin
        hold <= 16'h0032;
        press_disp <= 1'b1;
      end else begin
        press_disp <= 1'b0;
      end
    end
    for (int i = 0; i < 6; i++) check(c[i], e[i]);
    for (int i = 6; i < 9; i++) check(c[i], e[i]);
    check(c[9], e[9]);
    check(c[10], e[10]);
    check(c[11], e[11]);
    for (int i = 0; i < 3; i++) check(ci[i], (d / 4));
    for (int i = 0; i < 7; i++) check(cs[i], (d / 32));
  endtask

  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    #1 check(run_cycle_flag_n, 1'b1);
    check({run_cycle_flag, start_pulse, phase, strobe}, 0);
    reg_read(2'h0, v);
    check(v, 8'h01);
    reg_read(2'h1, v);
    check(v & 8'h1f, 8'h00);
    for (int a = 2; a < 4; a++) begin
      reg_write(2'(a), 8'hff);
      reg_read(2'(a), v);
      check(v, 8'h00);
    end
    press(1'b0, 1'b1, 1'b1);
    press(1'b1, 1'b1, 1'b0);
    press(1'b0, 1'b1, 1'b0);
    reg_write(2'h0, 8'h00);
    press(1'b1, 1'b0, 1'b0);
    reg_write(2'h0, 8'h01);
    reg_read(2'h0, v);
    check(v, 8'h01);
    finish_test();
  end

  // Watchdog well beyond the expected run of some 3000 cycles
  initial begin
    #200000;
    fail_count++;
    finish_test();
  end
endmodule
